/* hdl/pbs_defs.vh */
`ifndef PBS_DEFS_VH
`define PBS_DEFS_VH

// Array geometry
`define PBS_ADDR_W 18
`define PBS_DATA_W 18
`define PBS_LANE_W 9
`define PBS_DEPTH 262144

// Chip select levels that count as active
`define PBS_CS1_ACTIVE 1'h0
`define PBS_CS2_ACTIVE 1'h1
`define PBS_CS3_ACTIVE 1'h0

// Access kinds carried through the pipeline and burst tracker
`define PBS_OP_NONE 2'h0
`define PBS_OP_READ 2'h1
`define PBS_OP_WRITE 2'h2

// Burst order select values
`define PBS_ORDER_LINEAR 1'h0
`define PBS_ORDER_INTERLEAVED 1'h1

// Sleep entry and exit span in clock cycles
`define PBS_SLEEP_CYCLES 2

// Reset values
`define PBS_ADDR_RST 18'h0_0000
`define PBS_DATA_RST 18'h0_0000
`define PBS_CNT_RST 2'h0
`define PBS_LANES_RST 2'h0

`endif

/* hdl/pbs_sram_core.v */
`timescale 1ns/1ps
`include "pbs_defs.vh"
module pbs_sram_core (
  input wire CORE_CLK_I,
  input wire RST_I,
  input wire [`PBS_ADDR_W-1:0] ADDR_I,
  input wire CLOCK_QUALIFY_N_I,
  input wire CHIP_SELECT_ONE_N_I,
  input wire CHIP_SELECT_TWO_I,
  input wire CHIP_SELECT_THREE_N_I,
  input wire ADVANCE_OR_LOAD_I,
  input wire WRITE_STROBE_N_I,
  input wire LANE_A_WRITE_SELECT_N_I,
  input wire LANE_B_WRITE_SELECT_N_I,
  input wire OUTPUT_DRIVE_ENABLE_N_I,
  input wire ORDER_SELECT_I,
  input wire SLEEP_REQUEST_I,
  input wire [`PBS_DATA_W-1:0] DQ_I,
  output wire [`PBS_DATA_W-1:0] DQ_O,
  output wire DQ_OE_O,
  output wire SLEEP_ACTIVE_O
);

  // --------------------------------------------------------------
  // Storage and state
  // --------------------------------------------------------------
  reg [`PBS_DATA_W-1:0] mem [0:`PBS_DEPTH-1];
  reg sleep_meta;
  reg sleep_sync;
  reg [`PBS_SLEEP_CYCLES-1:0] sleep_hist;
  reg sleep_active;
  reg [1:0] burst_kind;
  reg [`PBS_ADDR_W-1:0] burst_base;
  reg [1:0] burst_cnt;
  reg burst_order;
  reg [1:0] p1_op;
  reg [`PBS_ADDR_W-1:0] p1_addr;
  reg [1:0] p1_lanes;
  reg [1:0] p2_op;
  reg [`PBS_ADDR_W-1:0] p2_addr;
  reg [1:0] p2_lanes;
  reg [`PBS_DATA_W-1:0] dout;
  reg read_drive;

  // Burst beat address from base, beat count and order
  function [`PBS_ADDR_W-1:0] beat_addr;
    input [`PBS_ADDR_W-1:0] base;
    input [1:0] cnt;
    input order;
    reg [1:0] low;
    begin
      if (order == `PBS_ORDER_INTERLEAVED) begin
        low = base[1:0] ^ cnt;
      end else begin
        low = base[1:0] + cnt;
      end
      beat_addr = {base[`PBS_ADDR_W-1:2], low};
    end
  endfunction

  // Lane mask: low lane with its parity bit, high lane with its parity bit
  function [`PBS_DATA_W-1:0] lane_mask;
    input [1:0] lanes;
    begin
      lane_mask = {{`PBS_LANE_W{lanes[1]}}, {`PBS_LANE_W{lanes[0]}}};
    end
  endfunction

  // --------------------------------------------------------------
  // Edge qualification and command decode
  // --------------------------------------------------------------
  wire selected = (CHIP_SELECT_ONE_N_I == `PBS_CS1_ACTIVE) &&
                  (CHIP_SELECT_TWO_I == `PBS_CS2_ACTIVE) &&
                  (CHIP_SELECT_THREE_N_I == `PBS_CS3_ACTIVE);
  wire qualified = ~CLOCK_QUALIFY_N_I;
  wire [1:0] lanes_in = {~LANE_B_WRITE_SELECT_N_I, ~LANE_A_WRITE_SELECT_N_I};

  reg [1:0] cmd_op;
  reg [`PBS_ADDR_W-1:0] cmd_addr;
  reg [1:0] cmd_lanes;
  reg [1:0] next_kind;
  reg [`PBS_ADDR_W-1:0] next_base;
  reg [1:0] next_cnt;
  reg next_order;

  // Decide the cycle taken at this edge
  always @* begin
    cmd_op = `PBS_OP_NONE;
    cmd_addr = beat_addr(burst_base, burst_cnt, burst_order);
    cmd_lanes = `PBS_LANES_RST;
    next_kind = burst_kind;
    next_base = burst_base;
    next_cnt = burst_cnt;
    next_order = burst_order;
    if (ADVANCE_OR_LOAD_I) begin
      // Continue burst; selects and strobe ignored
      if (burst_kind != `PBS_OP_NONE) begin
        next_cnt = burst_cnt + 2'h1;
        cmd_addr = beat_addr(burst_base, next_cnt, burst_order);
        if (burst_kind == `PBS_OP_READ) begin
          cmd_op = `PBS_OP_READ;
        end else if (lanes_in != 2'h0) begin
          cmd_op = `PBS_OP_WRITE;
          cmd_lanes = lanes_in;
        end else begin
          cmd_op = `PBS_OP_NONE;
        end
      end
    end else if (selected) begin
      next_base = ADDR_I;
      next_cnt = `PBS_CNT_RST;
      next_order = ORDER_SELECT_I;
      cmd_addr = ADDR_I;
      if (WRITE_STROBE_N_I) begin
        next_kind = `PBS_OP_READ;
        cmd_op = `PBS_OP_READ;
      end else begin
        next_kind = `PBS_OP_WRITE;
        if (lanes_in != 2'h0) begin
          cmd_op = `PBS_OP_WRITE;
          cmd_lanes = lanes_in;
        end else begin
          cmd_op = `PBS_OP_NONE;
        end
      end
    end else begin
      next_kind = `PBS_OP_NONE;
    end
  end

  // --------------------------------------------------------------
  // Sleep request synchroniser and two-cycle entry and exit
  // --------------------------------------------------------------
  always @(posedge CORE_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      sleep_meta <= 1'h0;
      sleep_sync <= 1'h0;
      sleep_hist <= {`PBS_SLEEP_CYCLES{1'h0}};
      sleep_active <= 1'h0;
    end else begin
      sleep_meta <= SLEEP_REQUEST_I;
      sleep_sync <= sleep_meta;
      sleep_hist <= {sleep_hist[`PBS_SLEEP_CYCLES-2:0], sleep_sync};
      if (&sleep_hist) begin
        sleep_active <= 1'h1;
      end else if (~|sleep_hist) begin
        sleep_active <= 1'h0;
      end
    end
  end

  // --------------------------------------------------------------
  // Burst tracker, pipeline and read output register
  // --------------------------------------------------------------
  wire [`PBS_DATA_W-1:0] wr_mask = lane_mask(p2_lanes);
  wire p2_writes = (p2_op == `PBS_OP_WRITE);
  wire bypass = p2_writes && (p2_addr == p1_addr);
  wire [`PBS_DATA_W-1:0] rd_word = bypass ?
    ((mem[p1_addr] & ~wr_mask) | (DQ_I & wr_mask)) : mem[p1_addr];

  always @(posedge CORE_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      burst_kind <= `PBS_OP_NONE;
      burst_base <= `PBS_ADDR_RST;
      burst_cnt <= `PBS_CNT_RST;
      burst_order <= `PBS_ORDER_LINEAR;
      p1_op <= `PBS_OP_NONE;
      p1_addr <= `PBS_ADDR_RST;
      p1_lanes <= `PBS_LANES_RST;
      p2_op <= `PBS_OP_NONE;
      p2_addr <= `PBS_ADDR_RST;
      p2_lanes <= `PBS_LANES_RST;
      dout <= `PBS_DATA_RST;
      read_drive <= 1'h0;
    end else if (sleep_active) begin
      // Pending accesses dropped in snooze
      burst_kind <= `PBS_OP_NONE;
      p1_op <= `PBS_OP_NONE;
      p2_op <= `PBS_OP_NONE;
      read_drive <= 1'h0;
    end else if (qualified) begin
      burst_kind <= next_kind;
      burst_base <= next_base;
      burst_cnt <= next_cnt;
      burst_order <= next_order;
      p1_op <= cmd_op;
      p1_addr <= cmd_addr;
      p1_lanes <= cmd_lanes;
      p2_op <= p1_op;
      p2_addr <= p1_addr;
      p2_lanes <= p1_lanes;
      if (p1_op == `PBS_OP_READ) begin
        dout <= rd_word;
        read_drive <= 1'h1;
      end else begin
        read_drive <= 1'h0;
      end
    end
  end

  // Array write on the data edge of a write beat
  always @(posedge CORE_CLK_I) begin
    if (qualified && !sleep_active && p2_writes) begin
      mem[p2_addr] <= (mem[p2_addr] & ~wr_mask) | (DQ_I & wr_mask);
    end
  end

  // --------------------------------------------------------------
  // Data line drive
  // --------------------------------------------------------------
  assign DQ_O = dout;
  // Enable acts without the clock on the registered read window
  assign DQ_OE_O = read_drive & ~OUTPUT_DRIVE_ENABLE_N_I & ~sleep_active;
  assign SLEEP_ACTIVE_O = sleep_active;

endmodule // pbs_sram_core

/* test/pbs_ctrl_model.sv */
`timescale 1ns/1ps
module pbs_ctrl_model (
  input wire clk_i,
  input wire [17:0] dq_o_i,
  input wire dq_oe_i,
  input wire drv_i,
  input wire [17:0] drv_data_i,
  output wire [17:0] bus_o
);
  reg [17:0] last = 18'h0_0000;
  // Released lines toggle so a stale value never reads back
  always @(posedge clk_i) begin
    last <= bus_o;
  end
  // Shared lines: device, else controller write data
  assign bus_o = dq_oe_i ? dq_o_i : (drv_i ? drv_data_i : ~last);
endmodule // pbs_ctrl_model

/* test/pbs_sram_checker.sv */
`timescale 1ns/1ps
`include "pbs_defs.vh"
module pbs_sram_checker (
  input wire CORE_CLK_I,
  input wire RST_I,
  input wire CLOCK_QUALIFY_N_I,
  input wire CHIP_SELECT_ONE_N_I,
  input wire CHIP_SELECT_TWO_I,
  input wire CHIP_SELECT_THREE_N_I,
  input wire ADVANCE_OR_LOAD_I,
  input wire WRITE_STROBE_N_I,
  input wire OUTPUT_DRIVE_ENABLE_N_I,
  input wire SLEEP_REQUEST_I,
  input wire [`PBS_DATA_W-1:0] DQ_O,
  input wire DQ_OE_O,
  input wire SLEEP_ACTIVE_O
);
  // Qualified edge and full selection
  wire q = !CLOCK_QUALIFY_N_I && !SLEEP_ACTIVE_O;
  wire sel = !CHIP_SELECT_ONE_N_I && CHIP_SELECT_TWO_I && !CHIP_SELECT_THREE_N_I;
  wire ld = q && !ADVANCE_OR_LOAD_I;
  default clocking cb @(posedge CORE_CLK_I); endclocking
  default disable iff (RST_I);
  // Load followed by one more qualified edge
  sequence s_rd; ld && sel && WRITE_STROBE_N_I ##1 q; endsequence
  sequence s_wr; ld && sel && !WRITE_STROBE_N_I ##1 q; endsequence
  sequence s_ds; ld && !sel ##1 q; endsequence
  AST_READ_OE: assert property (s_rd |=> DQ_OE_O == (!OUTPUT_DRIVE_ENABLE_N_I && !SLEEP_ACTIVE_O))
    else $error("read drive wrong");
  AST_WRITE_TRI: assert property (s_wr |=> !DQ_OE_O)
    else $error("drive during write");
  AST_DESEL_TRI: assert property (s_ds |=> !DQ_OE_O)
    else $error("drive after deselect");
  AST_OE_ASYNC: assert property (OUTPUT_DRIVE_ENABLE_N_I |-> !DQ_OE_O)
    else $error("drive with enable off");
  AST_STALL_HOLD: assert property (CLOCK_QUALIFY_N_I && !SLEEP_ACTIVE_O |=>
    SLEEP_ACTIVE_O || $stable(DQ_O))
    else $error("data moved on stall");
  AST_SLEEP_IN: assert property ($rose(SLEEP_REQUEST_I) && !SLEEP_ACTIVE_O |->
    (!SLEEP_ACTIVE_O)[*2] ##[1:4] (SLEEP_ACTIVE_O || !SLEEP_REQUEST_I))
    else $error("snooze entry timing");
  AST_SLEEP_OUT: assert property ($fell(SLEEP_REQUEST_I) && SLEEP_ACTIVE_O |->
    SLEEP_ACTIVE_O[*2] ##[1:4] (!SLEEP_ACTIVE_O || SLEEP_REQUEST_I))
    else $error("snooze exit timing");
  AST_SLEEP_TRI: assert property (SLEEP_ACTIVE_O |-> !DQ_OE_O)
    else $error("drive in snooze");
  AST_RESET: assert property ($fell(RST_I) |-> !DQ_OE_O && !SLEEP_ACTIVE_O && DQ_O == 18'h0_0000)
    else $error("state after reset");
endmodule // pbs_sram_checker

bind pbs_sram_core pbs_sram_checker u_chk (.CORE_CLK_I(CORE_CLK_I), .RST_I(RST_I),
  .CLOCK_QUALIFY_N_I(CLOCK_QUALIFY_N_I), .CHIP_SELECT_ONE_N_I(CHIP_SELECT_ONE_N_I),
  .CHIP_SELECT_TWO_I(CHIP_SELECT_TWO_I), .CHIP_SELECT_THREE_N_I(CHIP_SELECT_THREE_N_I),
  .ADVANCE_OR_LOAD_I(ADVANCE_OR_LOAD_I), .WRITE_STROBE_N_I(WRITE_STROBE_N_I),
  .OUTPUT_DRIVE_ENABLE_N_I(OUTPUT_DRIVE_ENABLE_N_I), .SLEEP_REQUEST_I(SLEEP_REQUEST_I),
  .DQ_O(DQ_O), .DQ_OE_O(DQ_OE_O), .SLEEP_ACTIVE_O(SLEEP_ACTIVE_O));

/* test/pbs_sram_core_test.sv */
`timescale 1ns/1ps
module pbs_sram_core_test;
  reg clk = 1'h0, rst = 1'h1, cqn = 1'h0, cs2 = 1'h0, adv = 1'h0, wen = 1'h1, oen = 1'h0;
  reg la_n = 1'h1, lb_n = 1'h1, ord = 1'h0, slp = 1'h0, drv = 1'h0;
  reg cs1_n = 1'h0, cs3_n = 1'h0;
  reg [17:0] addr = 18'h0_0000, wd = 18'h0_0000;
  reg [17:0] mem [0:7];
  wire [17:0] dq_i, dq_o;
  wire dq_oe, slp_act;
  integer errors = 0, cmp_count = 0, i;
  pbs_sram_core dut (.CORE_CLK_I(clk), .RST_I(rst), .ADDR_I(addr), .CLOCK_QUALIFY_N_I(cqn),
    .CHIP_SELECT_ONE_N_I(cs1_n), .CHIP_SELECT_TWO_I(cs2), .CHIP_SELECT_THREE_N_I(cs3_n),
    .ADVANCE_OR_LOAD_I(adv), .WRITE_STROBE_N_I(wen), .LANE_A_WRITE_SELECT_N_I(la_n),
    .LANE_B_WRITE_SELECT_N_I(lb_n), .OUTPUT_DRIVE_ENABLE_N_I(oen), .ORDER_SELECT_I(ord),
    .SLEEP_REQUEST_I(slp), .DQ_I(dq_i), .DQ_O(dq_o), .DQ_OE_O(dq_oe), .SLEEP_ACTIVE_O(slp_act));
  pbs_ctrl_model u_ctl (.clk_i(clk), .dq_o_i(dq_o), .dq_oe_i(dq_oe), .drv_i(drv),
    .drv_data_i(wd), .bus_o(dq_i));
  // Clock, 100 ns period
  always #50 clk = ~clk;
  task print_verdict;
    if (errors == 0 && cmp_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task chk(input string n, input [17:0] e, input [17:0] s);
    cmp_count = cmp_count + 1;
    if (s !== e) begin
      errors = errors + 1;
      $display("ERROR %s expected %h seen %h", n, e, s);
    end
  endtask
  // One command, driven just after the edge
  task cyc(input s, input v, input w, input [1:0] ln, input [17:0] a);
    @(posedge clk);
    #1;
    cqn = 1'h0;
    cs2 = s;
    adv = v;
    wen = w;
    {lb_n, la_n} = ln;
    addr = a;
  endtask
  // Burst beat address, linear or interleaved
  function [17:0] ba(input [17:0] b, input o, input [1:0] k);
    ba = o ? b ^ k : {b[17:2], b[1:0] + k};
  endfunction
  // Four-beat write, data two edges after each beat
  task wr(input [17:0] b, input o, input [1:0] ln, input [17:0] s);
    reg [17:0] a;
    ord = o;
    for (i = 0; i < 6; i = i + 1) begin
      cyc(i == 0, i > 0 && i < 4, i > 0, ln, b);
      chk("drive", 18'h0_0000, dq_oe);
      drv = i > 1;
      a = ba(b, o, i - 2);
      wd = s + i;
      if (drv) mem[a] = {ln[1] ? mem[a][17:9] : wd[17:9], ln[0] ? mem[a][8:0] : wd[8:0]};
    end
    @(posedge clk);
    #1;
    drv = 1'h0;
  endtask
  // Four-beat read, optional stall after the third command
  task rd(input [17:0] b, input o, input st);
    ord = o;
    for (i = 0; i < 7; i = i + 1) begin
      cyc(i == 0, i > 0 && i < 4, 1'h1, 2'h0, b);
      if (i > 1 && i < 6 && !oen) chk("rdata", mem[ba(b, o, i - 2)], dq_o);
      if (i > 1) chk("drive", i < 6 && !oen, dq_oe);
      if (st && i == 2) begin
        @(posedge clk);
        #1;
        cqn = 1'h1;
      end
    end
  endtask
  // Bounded wait for the snooze flag
  task wt(input v);
    for (i = 0; i < 8 && slp_act !== v; i = i + 1) @(posedge clk);
    #1;
    chk("snooze", v, slp_act);
    if (slp_act !== v) print_verdict;
  endtask
  // Load with one chip select inactive ends the read, advance then idles
  task ds;
    for (i = 0; i < 3; i = i + 1) begin
      cyc(1'h1, 1'h0, 1'h1, 2'h3, 18'h0_0007);
      cyc(i != 1, 1'h0, 1'h1, 2'h3, 18'h0_0000);
      cs1_n = i == 0;
      cs3_n = i == 2;
      cyc(1'h1, 1'h1, 1'h0, 2'h0, 18'h0_0000);
      chk("rdata", mem[7], dq_o);
      chk("drive", 18'h0_0001, dq_oe);
      cyc(1'h1, 1'h1, 1'h0, 2'h0, 18'h0_0000);
      chk("drive", 18'h0_0000, dq_oe);
      cyc(1'h1, 1'h1, 1'h0, 2'h0, 18'h0_0000);
      chk("drive", 18'h0_0000, dq_oe);
      cs1_n = 1'h0;
      cs3_n = 1'h0;
    end
  endtask
  initial begin
    repeat (3) @(posedge clk);
    #1;
    rst = 1'h0;
    chk("drive", 18'h0_0000, dq_oe);
    wr(18'h0_0000, 1'h0, 2'h0, 18'h1_1000);
    wr(18'h0_0006, 1'h1, 2'h0, 18'h2_2000);
    rd(18'h0_0005, 1'h1, 1'h0);
    rd(18'h0_0003, 1'h0, 1'h1);
    wr(18'h0_0002, 1'h0, 2'h2, 18'h3_3300);
    wr(18'h0_0005, 1'h1, 2'h1, 18'h0_4400);
    wr(18'h0_0004, 1'h0, 2'h3, 18'h0_5500);
    rd(18'h0_0000, 1'h0, 1'h0);
    rd(18'h0_0004, 1'h0, 1'h0);
    oen = 1'h1;
    rd(18'h0_0000, 1'h1, 1'h0);
    oen = 1'h0;
    ds;
    slp = 1'h1;
    wt(1'h1);
    chk("drive", 18'h0_0000, dq_oe);
    slp = 1'h0;
    wt(1'h0);
    rd(18'h0_0001, 1'h1, 1'h0);
    print_verdict;
  end
endmodule // pbs_sram_core_test
